//--- design/pfswc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - calibration select 1 reads test area, 0 reads user area; reads only.
// - write enable set permits writes; clear blocks every program write.
// - write start begins a write; hardware clears it; software zero ignored.
// - read start runs one read; hardware clears it; software cannot clear.
// - control bit 7 reads one, bits 5 to 3 read zero, writes ignored.
// - address loaded first; fetch uses second cycle after read start.
// - read data lands next cycle; held until next read or overwrite.
// - writes into protected segments refused; reads and execution still allowed.
// - write protection ignored while external serial programming is active.
// - unlocked write at non-last word only latches data into buffer.
// - array programming only from unlocked write at low bits 111.
// - last-word write erases surrounding sixteen words, then programs buffer.
// - block is eight aligned consecutive words; never spans two blocks.
// - two setup cycles after write start; execution resumes third instruction.
// - erase halts CPU about 4 ms; clocks and peripherals keep running.
// - conflicting 0011 erase trigger resolved to the eight-word 111 trigger.
// - write enable clear at power-up; no writes while power-up timer runs.
// - with code protection CPU access stays, test memory access disabled.
// - write requested with calibration select set performs no write.
// - unlock register stores nothing and reads zero.
// - data pair is a 14-bit word, address pair a 13-bit address.
////////////////////////////////////////////////////////////////////////////////
package pfswc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_ADR_LO = 8'h08;
  localparam logic [7:0] OFS_ADR_HI = 8'h0c;
  localparam logic [7:0] OFS_DAT_LO = 8'h10;
  localparam logic [7:0] OFS_DAT_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // control register fields
  localparam int CTRL_RD     = 0;
  localparam int CTRL_WR     = 1;
  localparam int CTRL_FLASH_WRITE_ENABLE   = 2;
  localparam int CTRL_CALIBRATION_AREA_SELECT = 6;
  localparam int CTRL_ONE    = 7;

  // reset values
  localparam logic [7:0]  ADR_LO_RST = 8'h00;
  localparam logic [4:0]  ADR_HI_RST = 5'h00;
  localparam logic [13:0] DATA_RST   = 14'h0000;

  // widths
  localparam int AW = 13;
  localparam int DW = 14;
  localparam int BLK_WORDS = 8;

  // unlock keys and block layout
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [2:0] BLK_LAST    = 3'h7;

  // timing
  localparam int CLK_KHZ      = 50000;
  localparam int ERASE_TIME_MS = 4;
  localparam int PWRT_TIME_MS  = 72;
  localparam int ERASE_CYC = ERASE_TIME_MS * CLK_KHZ;
  localparam int PWRT_CYC  = PWRT_TIME_MS * CLK_KHZ;
  localparam int SETUP_CYC = 2;
  localparam int PROG_CYC  = 64;

  // write-protect field decode: protected upper bound (exclusive)
  localparam logic [1:0]  WP_NONE   = 2'h3;
  localparam logic [1:0]  WP_LOW    = 2'h2;
  localparam logic [1:0]  WP_HALF   = 2'h1;
  localparam logic [13:0] WP_LOW_TOP  = 14'h0400;
  localparam logic [13:0] WP_HALF_TOP = 14'h1000;

  typedef struct packed {
    logic          rd;
    logic          erase;
    logic          prog;
    logic          test_sel;
    logic [AW-1:0] addr;
  } pfswc_flash_cmd_t;

  typedef struct packed {
    logic [1:0] write_protect_field;
    logic       code_protect;
    logic       ext_prog_active;
  } pfswc_fuse_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_FETCH, ST_WR_SETUP, ST_ERASE, ST_PROG
  } pfswc_state_t;

endpackage : pfswc_pkg

//--- design/pfswc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module pfswc_ctrl
  import pfswc_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PWRT_CYCLES  = PWRT_CYC,
  parameter int PROG_CYCLES  = PROG_CYC
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // configuration fuses, asynchronous
  input  wire pfswc_fuse_t            fuse_in,
  // flash array
  output pfswc_flash_cmd_t            flash_cmd,
  output logic [BLK_WORDS*DW-1:0]     flash_prog_words,
  input  wire logic [DW-1:0]          flash_rdata,
  // cpu
  output logic                        flash_cpu_halt
);

  ////////////////////////////////////////////////////////////////////////////
  // fuse synchroniser
  pfswc_fuse_t fuse_s1_r;
  pfswc_fuse_t fuse_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_s1_r <= '0;
      fuse_r    <= '0;
    end else begin
      fuse_s1_r <= fuse_in;
      fuse_r    <= fuse_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  logic       dp_valid_r;
  logic       dp_write_r;
  logic [7:0] dp_addr_r;
  logic       rd_wait_r;
  logic [31:0] hrdata_r;
  logic       addr_ok;
  logic       wr_done;
  logic       acc_done;

  assign addr_ok = hsel && htrans[1] && hready;
  // reads take one wait state so hrdata comes from a flop
  assign hreadyout = !(dp_valid_r && !dp_write_r && !rd_wait_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign acc_done = dp_valid_r && hreadyout;
  assign wr_done = acc_done && dp_write_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
    end else if (hready) begin
      dp_valid_r <= addr_ok;
      dp_write_r <= hwrite;
      dp_addr_r  <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= dp_valid_r && !dp_write_r && !rd_wait_r;
    end
  end

  function automatic logic is_wr(input logic [7:0] ofs, input logic [7:0] a);
    return a == ofs;
  endfunction : is_wr

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic             calibration_area_select_r;
  logic             flash_write_enable_r;
  logic             wr_r;
  logic             rd_r;
  logic [7:0]       adr_lo_r;
  logic [4:0]       adr_hi_r;
  logic [DW-1:0]    data_r;
  logic [DW-1:0]    buf_r [BLK_WORDS];
  logic [AW-1:0]    adr;
  pfswc_state_t     state_r;
  logic [31:0]      cnt_r;
  logic             halt_r;
  logic             pwrt_run_r;
  logic [31:0]      pwrt_cnt_r;
  logic [1:0]       ulk_r;
  logic             wr_req;
  logic             rd_req;
  logic             wr_ok;
  logic             wp_hit;
  logic             idle;
  logic             rd_fetch;
  logic             done_wr;

  assign adr  = {adr_hi_r, adr_lo_r};
  assign idle = state_r == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // power-up timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwrt_cnt_r <= 32'h0000_0000;
      pwrt_run_r <= 1'b1;
    end else if (pwrt_run_r) begin
      pwrt_cnt_r <= pwrt_cnt_r + 32'h0000_0001;
      if (pwrt_cnt_r == 32'(PWRT_CYCLES - 1)) begin
        pwrt_run_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ulk_r <= 2'd0;
    end else if (acc_done) begin
      // any access that does not continue the sequence aborts it
      if (dp_write_r && is_wr(OFS_UNLOCK, dp_addr_r)
          && hwdata[7:0] == UNLOCK_KEY1) begin
        ulk_r <= 2'd1;
      end else if (ulk_r == 2'd1 && dp_write_r && is_wr(OFS_UNLOCK, dp_addr_r)
                   && hwdata[7:0] == UNLOCK_KEY2) begin
        ulk_r <= 2'd2;
      end else begin
        ulk_r <= 2'd0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request qualification
  function automatic logic wp_decode(input logic [1:0] f, input logic [AW-1:0] a);
    logic [13:0] top;
    top = (f == WP_LOW) ? WP_LOW_TOP : (f == WP_HALF) ? WP_HALF_TOP : 14'h2000;
    return (f != WP_NONE) && ({1'b0, a} < top);
  endfunction : wp_decode

  // serial programming bypasses the self-write protection
  assign wp_hit = wp_decode(fuse_r.write_protect_field, adr)
                  && !fuse_r.ext_prog_active;

  assign wr_req = wr_done && is_wr(OFS_CTRL, dp_addr_r) && hwdata[CTRL_WR]
                  && !wr_r && idle && ulk_r == 2'd2;
  assign wr_ok = flash_write_enable_r
                 && !calibration_area_select_r
                 && !pwrt_run_r
                 && !wp_hit;
  assign rd_req = wr_done && is_wr(OFS_CTRL, dp_addr_r) && hwdata[CTRL_RD]
                  && !rd_r && idle && !wr_req;
  assign rd_fetch = state_r == ST_RD_FETCH;
  assign done_wr = (state_r == ST_PROG && cnt_r == 32'h0000_0000)
                   || (state_r == ST_WR_SETUP && cnt_r == 32'h0000_0000
                       && adr_lo_r[2:0] != BLK_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calibration_area_select_r <= 1'b0;
      flash_write_enable_r   <= 1'b0;
    end else if (wr_done && is_wr(OFS_CTRL, dp_addr_r)) begin
      calibration_area_select_r <= hwdata[CTRL_CALIBRATION_AREA_SELECT];
      flash_write_enable_r   <= hwdata[CTRL_FLASH_WRITE_ENABLE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
    end else if (wr_req && wr_ok) begin
      wr_r <= 1'b1;
    end else if (done_wr) begin
      wr_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'b0;
    end else if (rd_req) begin
      rd_r <= 1'b1;
    end else if (rd_fetch) begin
      rd_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adr_lo_r <= ADR_LO_RST;
      adr_hi_r <= ADR_HI_RST;
    end else if (wr_done && is_wr(OFS_ADR_LO, dp_addr_r)) begin
      adr_lo_r <= hwdata[7:0];
    end else if (wr_done && is_wr(OFS_ADR_HI, dp_addr_r)) begin
      adr_hi_r <= hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= DATA_RST;
    end else if (rd_fetch) begin
      // test area gated off under code protection
      data_r <= (calibration_area_select_r && fuse_r.code_protect) ? DATA_RST : flash_rdata;
    end else if (wr_done && is_wr(OFS_DAT_LO, dp_addr_r)) begin
      data_r[7:0] <= hwdata[7:0];
    end else if (wr_done && is_wr(OFS_DAT_HI, dp_addr_r)) begin
      data_r[DW-1:8] <= hwdata[5:0];
    end
  end

  // buffer word indexed by the low address bits, block aligned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < BLK_WORDS; i++) begin
        buf_r[i] <= DATA_RST;
      end
    end else if (wr_req && wr_ok) begin
      buf_r[adr_lo_r[2:0]] <= data_r;
    end
  end

  always_comb begin
    for (int i = 0; i < BLK_WORDS; i++) begin
      flash_prog_words[i*DW +: DW] = buf_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0000_0000;
      halt_r  <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (wr_req && wr_ok) begin
            state_r <= ST_WR_SETUP;
            cnt_r   <= 32'(SETUP_CYC - 1);
          end else if (rd_req) begin
            state_r <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: begin
          // first cycle after the set runs normally
          state_r <= ST_RD_FETCH;
          halt_r  <= 1'b1;
        end
        ST_RD_FETCH: begin
          state_r <= ST_IDLE;
          halt_r  <= 1'b0;
        end
        ST_WR_SETUP: begin
          if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end else if (adr_lo_r[2:0] == BLK_LAST) begin
            // erase trigger is the eight-word last location only
            state_r <= ST_ERASE;
            cnt_r   <= 32'(ERASE_CYCLES - 1);
            halt_r  <= 1'b1;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end else begin
            state_r <= ST_PROG;
            cnt_r   <= 32'(PROG_CYCLES - 1);
          end
        end
        ST_PROG: begin
          if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end else begin
            state_r <= ST_IDLE;
            halt_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  assign flash_cpu_halt = halt_r;

  ////////////////////////////////////////////////////////////////////////////
  // flash command, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.rd       <= state_r == ST_RD_WAIT;
      flash_cmd.erase    <= state_r == ST_WR_SETUP && cnt_r == 32'h0000_0000
                            && adr_lo_r[2:0] == BLK_LAST;
      flash_cmd.prog     <= state_r == ST_ERASE && cnt_r == 32'h0000_0000;
      // writes always target user space
      flash_cmd.test_sel <= calibration_area_select_r && !fuse_r.code_protect
                            && state_r == ST_RD_WAIT;
      if (state_r == ST_WR_SETUP) begin
        flash_cmd.addr <= {adr[AW-1:4], 4'h0};
      end else if (state_r == ST_ERASE) begin
        flash_cmd.addr <= {adr[AW-1:3], 3'h0};
      end else begin
        flash_cmd.addr <= adr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (dp_valid_r && !dp_write_r && !rd_wait_r) begin
      unique case (dp_addr_r)
        OFS_CTRL:   hrdata_r <= {24'h0, 1'b1, calibration_area_select_r, 3'b000,
                                 flash_write_enable_r, wr_r, rd_r};
        OFS_UNLOCK: hrdata_r <= 32'h0000_0000;
        OFS_ADR_LO: hrdata_r <= {24'h0, adr_lo_r};
        OFS_ADR_HI: hrdata_r <= {27'h0, adr_hi_r};
        OFS_DAT_LO: hrdata_r <= {24'h0, data_r[7:0]};
        OFS_DAT_HI: hrdata_r <= {26'h0, data_r[DW-1:8]};
        OFS_STATUS: hrdata_r <= {28'h0, pwrt_run_r, ulk_r == 2'd2,
                                 halt_r, !idle};
        default:    hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // hsize unused: only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0], hwdata[31:8]};

endmodule : pfswc_ctrl
`default_nettype wire

//--- test/pfswc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pfswc_ctrl_sva
  import pfswc_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // fuses, array and cpu
  input wire pfswc_fuse_t      fuse_in,
  input wire pfswc_flash_cmd_t flash_cmd,
  input wire logic             flash_cpu_halt
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////////
  // cycles since the erase strobe; 32 bits so a full-length erase fits
  logic [31:0] gap_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 32'h0;
    end else if (flash_cmd.erase) begin
      gap_r <= 32'h1;
    end else if (flash_cmd.prog) begin
      gap_r <= 32'h0;
    end else if (gap_r != 32'h0) begin
      gap_r <= gap_r + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  rd_pulse_a : assert property (
    flash_cmd.rd |=> !flash_cmd.rd) else $error("read strobe too long");
  rd_halt_a : assert property (
    flash_cmd.rd |-> flash_cpu_halt ##1 !flash_cpu_halt) else $error("read stall wrong");
  erase_align_a : assert property (
    flash_cmd.erase |-> flash_cmd.addr[3:0] == 4'h0 && flash_cpu_halt)
    else $error("erase misaligned or cpu running");
  prog_align_a : assert property (
    flash_cmd.prog |-> flash_cmd.addr[2:0] == 3'h0 && flash_cpu_halt)
    else $error("program misaligned or cpu running");
  erase_hold_a : assert property (
    flash_cmd.erase |=> flash_cpu_halt [*8]) else $error("halt dropped in erase");
  prog_hold_a : assert property (
    flash_cmd.prog |=> flash_cpu_halt [*2]) else $error("halt dropped in program");
  erase_gap_a : assert property (
    flash_cmd.prog |-> gap_r >= 32'(ERASE_CYCLES - 1) && gap_r <= 32'(ERASE_CYCLES + 1))
    else $error("erase time wrong");
  // fuse passes two sync flops and the select flop, so compare three samples back
  test_area_a : assert property (
    flash_cmd.rd && flash_cmd.test_sel |-> !$past(fuse_in.code_protect, 3))
    else $error("test area read while protected");
  cal_read_c : cover property (flash_cmd.rd && flash_cmd.test_sel);
  erase_c : cover property (flash_cmd.erase);
  prog_c : cover property (flash_cmd.prog ##1 flash_cpu_halt);
endmodule : pfswc_ctrl_sva
bind pfswc_ctrl pfswc_ctrl_sva #(.ERASE_CYCLES(ERASE_CYCLES)) pfswc_ctrl_sva_inst (
  .hclk(hclk), .hresetn(hresetn), .fuse_in(fuse_in), .flash_cmd(flash_cmd),
  .flash_cpu_halt(flash_cpu_halt));
`default_nettype wire

//--- test/pfswc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module pfswc_flash_model
  import pfswc_pkg::*;
(
  // clock
  input wire logic                    hclk,
  // array side
  input wire pfswc_flash_cmd_t        flash_cmd,
  input wire logic [BLK_WORDS*DW-1:0] flash_prog_words,
  output logic [DW-1:0]               flash_rdata
);
  logic [DW-1:0] mem [0:8191];
  logic [DW-1:0] word;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = (DW'(i) * 14'h5) ^ 14'h2a5;
    end
  end
  always @(posedge hclk) begin
    for (int i = 0; i < 16; i++) begin
      if (flash_cmd.erase) mem[flash_cmd.addr + AW'(i)] <= 14'h3fff;
    end
    for (int i = 0; i < BLK_WORDS; i++) begin
      if (flash_cmd.prog) mem[flash_cmd.addr + AW'(i)] <= flash_prog_words[i*DW +: DW];
    end
  end
  // test area answers with a marker; idle output flips so stale data never matches
  assign word = flash_cmd.test_sel ? {1'b1, flash_cmd.addr} : mem[flash_cmd.addr];
  assign flash_rdata = flash_cmd.rd ? word : ~word;
endmodule : pfswc_flash_model
`default_nettype wire

//--- test/test_program_flash_self_write_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_program_flash_self_write_ctrl
  import pfswc_pkg::*;
;
  logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_cpu_halt;
  logic [31:0]             haddr, hwdata, hrdata, rv, seed;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  logic [12:0]             a, b;
  logic [DW-1:0]           flash_rdata, e;
  logic [DW-1:0]           d [8];
  logic [BLK_WORDS*DW-1:0] flash_prog_words;
  pfswc_fuse_t             fuse_in;
  pfswc_flash_cmd_t        flash_cmd;
  int                      miscompares, total_checks;

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // short counts keep the run brief; expectations use the same figures
  pfswc_ctrl #(.ERASE_CYCLES(20), .PWRT_CYCLES(10), .PROG_CYCLES(4)) pfswc_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_in(fuse_in),
    .flash_cmd(flash_cmd), .flash_prog_words(flash_prog_words),
    .flash_rdata(flash_rdata), .flash_cpu_halt(flash_cpu_halt));
  pfswc_flash_model pfswc_flash_model_inst (.hclk(hclk), .flash_cmd(flash_cmd),
    .flash_prog_words(flash_prog_words), .flash_rdata(flash_rdata));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // array content before any programming
  function automatic logic [DW-1:0] fresh(input logic [12:0] x);
    return ({1'b0, x} * 14'h5) ^ 14'h2a5;
  endfunction : fresh
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rv = hrdata;
  endtask : bus
  task automatic fcheck(input logic [12:0] x, input logic [7:0] ctl, input logic [DW-1:0] ev);
    bus(1'b1, OFS_ADR_LO, x[7:0]);
    bus(1'b1, OFS_ADR_HI, {3'h0, x[12:8]});
    bus(1'b1, OFS_CTRL, ctl | 8'h01);
    repeat (3) @(posedge hclk);
    bus(1'b0, OFS_DAT_LO, 8'h00);
    check(rv, {24'h0, ev[7:0]});
    bus(1'b0, OFS_DAT_HI, 8'h00);
    check(rv, {26'h0, ev[13:8]});
  endtask : fcheck
  // brk 1 leaves out the keys, brk 2 slips a read between them
  task automatic wword(input logic [12:0] x, input logic [DW-1:0] v, input int brk,
                       input logic [7:0] ctl);
    int n;
    bus(1'b1, OFS_ADR_LO, x[7:0]);
    bus(1'b1, OFS_ADR_HI, {3'h0, x[12:8]});
    bus(1'b1, OFS_DAT_LO, v[7:0]);
    bus(1'b1, OFS_DAT_HI, {2'h0, v[13:8]});
    bus(1'b1, OFS_CTRL, ctl);
    if (brk != 1) bus(1'b1, OFS_UNLOCK, 8'h55);
    if (brk == 2) bus(1'b0, OFS_STATUS, 8'h00);
    if (brk != 1) bus(1'b1, OFS_UNLOCK, 8'haa);
    bus(1'b1, OFS_CTRL, ctl | 8'h02);
    if (x[2:0] == 3'h7 && brk == 0) begin
      bus(1'b1, OFS_CTRL, ctl);
      bus(1'b0, OFS_CTRL, 8'h00);
      #1 check({31'h0, rv[1]}, 32'h1);
      check({31'h0, flash_cpu_halt}, 32'h1);
    end
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 8'h00);
      n++;
    end while (rv[1] !== 1'b0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      give_verdict();
    end
  endtask : wword
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h16a0d;
    miscompares = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    fuse_in = '{2'h3, 1'b0, 1'b0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFS_STATUS, 8'h00);
    check({31'h0, rv[3]}, 32'h1);
    bus(1'b0, OFS_CTRL, 8'h00);
    check(rv, 32'h80);
    bus(1'b1, OFS_CTRL, 8'h78);
    bus(1'b1, 8'h1c, 8'hff);
    bus(1'b0, OFS_CTRL, 8'h00);
    check(rv, 32'hc0);
    bus(1'b1, OFS_UNLOCK, 8'h5a);
    bus(1'b0, OFS_UNLOCK, 8'h00);
    check(rv, 32'h0);
    bus(1'b0, OFS_STATUS, 8'h00);
    check({31'h0, rv[3]}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rv = rnd();
      a = rv[12:0];
      fcheck(a, 8'h00, fresh(a));
      fcheck(a, 8'h40, {1'b1, a});
    end
    fuse_in <= '{2'h3, 1'b1, 1'b0};
    fcheck(a, 8'h40, 14'h0000);
    rv = rnd();
    b = {1'b1, rv[11:3], 3'h0};
    // refused requests leave their slot empty; the serial port lets the last through
    for (int k = 0; k < 6; k++) begin
      rv = rnd();
      d[k] = rv[13:0] | 14'h1;
      fuse_in <= '{(k >= 4) ? 2'h0 : 2'h3, 1'b0, k == 5};
      wword(b + 13'(k), d[k], (k < 2) ? k + 1 : 0, (k == 2) ? 8'h00 : (k == 3) ? 8'h44 : 8'h04);
      e = (k == 5) ? d[k] : 14'h0;
      check({18'h0, flash_prog_words[k*DW +: DW]}, {18'h0, e});
    end
    fuse_in <= '{2'h3, 1'b0, 1'b0};
    for (int k = 0; k < 8; k++) begin
      rv = rnd();
      d[k] = rv[13:0];
      wword(b + 13'(k), d[k], 0, 8'h04);
      check({18'h0, flash_prog_words[k*DW +: DW]}, {18'h0, d[k]});
      if (k == 6) fcheck(b, 8'h04, fresh(b));
    end
    for (int k = 0; k < 8; k++) fcheck(b + 13'(k), 8'h04, d[k]);
    fcheck(b ^ 13'h8, 8'h04, 14'h3fff);
    fcheck(b ^ 13'h10, 8'h04, fresh(b ^ 13'h10));
    give_verdict();
  end
endmodule : test_program_flash_self_write_ctrl
`default_nettype wire
